// ### rtl/whst_pkg.sv
// Package with constants for the wire hit separator and trigger block
package whst_pkg;
  // Channel counts
  localparam int unsigned NUM_WIRES = 24;
  localparam int unsigned NUM_PAIRS = NUM_WIRES / 2;
  // Clock
  localparam int unsigned CLK_PERIOD_NS = 20;
  // Separator rearm time and its cycle count (longest time, rounded down)
  localparam int unsigned REARM_NS = 60;
  localparam int unsigned REARM_CYC = (REARM_NS / CLK_PERIOD_NS) < 1 ? 1 : (REARM_NS / CLK_PERIOD_NS);
  // Minimum discriminator pulse width and its cycle count (least time, rounded up)
  localparam int unsigned DISC_MIN_NS = 40;
  localparam int unsigned DISC_CYC = (DISC_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Maximum drift time and its cycle count
  localparam int unsigned DRIFT_NS = 800;
  localparam int unsigned DRIFT_CYC = (DRIFT_NS / CLK_PERIOD_NS) < 1 ? 1 : (DRIFT_NS / CLK_PERIOD_NS);
  // Counter widths
  localparam int unsigned SEP_CW = 3;
  localparam int unsigned OS_CW = 7;
  // Enable register reset value and counter load values
  localparam logic [NUM_WIRES-1:0] CHAN_EN_RESET = 24'hFFFFFF;
  localparam logic [SEP_CW-1:0] SEP_CNT_LOAD = SEP_CW'(REARM_CYC);
  localparam logic [SEP_CW-1:0] DISC_CNT_LOAD = SEP_CW'(DISC_CYC);
  localparam logic [OS_CW-1:0] OS_CNT_LOAD = OS_CW'(DRIFT_CYC);
  // Separator pair state
  typedef enum logic [2:0]
  {
    WHST_ARMED = 3'h1,
    WHST_HELD = 3'h2,
    WHST_WAIT_IDLE = 3'h4
  } whst_sep_e;
endpackage

// ### rtl/whst_top.sv
// Wire hit separator, discriminator stretcher and trigger one-shots
// Contract
// - Per pair, only the earlier wire latches; the other is locked out.
// - Both separator latches of a pair clear 60 ns after an output.
// - A later hit within the 60 ns resolution gives no trigger output.
// - Each discriminator pulse to the time digitizer lasts at least 40 ns.
// - Separator outputs fire retriggerable one-shots; new winning pulses restart full width.
// - One-shot output lasts the maximum drift time.
// - A channel enable register enables or disables each of 24 wires.
`timescale 1ns/1ps
`default_nettype none
module whst_top
(
  // Clock, reset, enable
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  // Discriminator pulses from the wire channels
  input wire logic [whst_pkg::NUM_WIRES-1:0] wire_hit_i,
  // Channel enable load from the control card
  input wire logic chan_en_we_i,
  input wire logic [whst_pkg::NUM_WIRES-1:0] chan_en_data_i,
  // Outputs
  output logic [whst_pkg::NUM_WIRES-1:0] chan_en_o,
  output logic [whst_pkg::NUM_WIRES-1:0] sep_hit_o,
  output logic [whst_pkg::NUM_WIRES-1:0] tdc_pulse_o,
  output logic [whst_pkg::NUM_WIRES-1:0] trig_o
);

  localparam int unsigned NW = whst_pkg::NUM_WIRES;
  localparam int unsigned NP = whst_pkg::NUM_PAIRS;

  // All state of the block but the reset synchroniser in one record
  // Pair p is made of wires 2p and 2p+1
  typedef struct packed
  {
    // First synchroniser stage of each wire pin
    logic [NW-1:0] sync1;
    // Second synchroniser stage, the only stage logic reads
    logic [NW-1:0] sync2;
    // Previous second-stage level, for edge detection
    logic [NW-1:0] last;
    // Channel enable register, one bit per wire
    logic [NW-1:0] chan_en;
    // Separator latches, the winning wire's high while its pair is held
    logic [NW-1:0] latch;
    // One-cycle winning pulse that fires the one-shot
    logic [NW-1:0] sep_out;
    // Stretched pulse towards the time digitiser
    logic [NW-1:0] tdc;
    // One-shot levels towards the control card
    logic [NW-1:0] trig;
    // Arm state of each pair
    whst_pkg::whst_sep_e [NP-1:0] pstate;
    // Rearm down counter of each pair
    logic [NP-1:0][whst_pkg::SEP_CW-1:0] rearm_cnt;
    // Minimum width down counter of each wire
    logic [NW-1:0][whst_pkg::SEP_CW-1:0] disc_cnt;
    // Drift time down counter of each wire
    logic [NW-1:0][whst_pkg::OS_CW-1:0] os_cnt;
  } whst_state_s;

  // Reset release stages and the released copy
  logic [1:0] rst_sync_r;
  logic rst_n;

  // Registered state and its next value
  whst_state_s st_r;
  whst_state_s st_nxt;

  // Reset release through two flip-flops
  // Assertion stays asynchronous; release is aligned to the clock
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rst_sync_r <= 2'h0;
    else
      rst_sync_r <= {rst_sync_r[0], 1'h1};
  end
  assign rst_n = rst_sync_r[1];

  // Rising edge of a synchronised, enabled wire pulse
  // The edge reference resets low, like an idle wire, so no false edge
  function automatic logic rise(input logic cur, input logic prev, input logic en);
    rise = cur & ~prev & en;
  endfunction

  // Minimum width stretcher: reload on a new edge, else count to zero
  function automatic logic [whst_pkg::SEP_CW-1:0] disc_step(input logic hit,
    input logic [whst_pkg::SEP_CW-1:0] cnt);
    if (hit)
      disc_step = whst_pkg::DISC_CNT_LOAD;
    else if (cnt != '0)
      disc_step = cnt - whst_pkg::SEP_CW'(1);
    else
      disc_step = '0;
  endfunction

  // Drift one-shot: a winning pulse restarts the full width
  // Retrigger matters when a second hit falls inside one drift time
  function automatic logic [whst_pkg::OS_CW-1:0] os_step(input logic fire,
    input logic [whst_pkg::OS_CW-1:0] cnt);
    if (fire)
      os_step = whst_pkg::OS_CNT_LOAD;
    else if (cnt != '0)
      os_step = cnt - whst_pkg::OS_CW'(1);
    else
      os_step = '0;
  endfunction

  // Next state of all channels and pairs
  always_comb
  begin
    logic ea;
    logic eb;
    ea = 1'h0;
    eb = 1'h0;
    st_nxt = st_r;

    // Two-stage synchroniser and edge reference
    st_nxt.sync1 = wire_hit_i;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.last = st_r.sync2;

    // Channel enable load from the control card
    if (chan_en_we_i)
      st_nxt.chan_en = chan_en_data_i;

    // First-arrival separator of each pair
    for (int p = 0; p < NP; p++)
    begin
      // Disabled wires never produce an edge
      ea = rise(st_r.sync2[2*p], st_r.last[2*p], st_r.chan_en[2*p]);
      eb = rise(st_r.sync2[2*p+1], st_r.last[2*p+1], st_r.chan_en[2*p+1]);
      st_nxt.sep_out[2*p] = 1'h0;
      st_nxt.sep_out[2*p+1] = 1'h0;
      unique case (st_r.pstate[p])
        whst_pkg::WHST_ARMED:
        begin
          // First arrival wins; a tie goes to the even wire
          // Each latch locks the other out, as cross-coupled flops would
          if (ea || eb)
          begin
            st_nxt.latch[2*p] = ea;
            st_nxt.latch[2*p+1] = eb & ~ea;
            st_nxt.sep_out[2*p] = ea;
            st_nxt.sep_out[2*p+1] = eb & ~ea;
            st_nxt.rearm_cnt[p] = whst_pkg::SEP_CNT_LOAD;
            st_nxt.pstate[p] = whst_pkg::WHST_HELD;
          end
        end
        whst_pkg::WHST_HELD:
        begin
          // Later hits ignored until the rearm time expires
          // A second track inside this time is lost for the trigger
          if (st_r.rearm_cnt[p] <= whst_pkg::SEP_CW'(1))
          begin
            st_nxt.latch[2*p] = 1'h0;
            st_nxt.latch[2*p+1] = 1'h0;
            st_nxt.rearm_cnt[p] = '0;
            st_nxt.pstate[p] = whst_pkg::WHST_ARMED;
          end
          else
          begin
            st_nxt.rearm_cnt[p] = st_r.rearm_cnt[p] - whst_pkg::SEP_CW'(1);
          end
        end
        default:
        begin
          // Unused or corrupt code: clear the pair and rearm
          st_nxt.pstate[p] = whst_pkg::WHST_ARMED;
          st_nxt.latch[2*p] = 1'h0;
          st_nxt.latch[2*p+1] = 1'h0;
          st_nxt.rearm_cnt[p] = '0;
        end
      endcase
    end

    // Per-wire stretcher and one-shot
    for (int w = 0; w < NW; w++)
    begin
      // Discriminator pulse stretched to its minimum width
      st_nxt.disc_cnt[w] = disc_step(rise(st_r.sync2[w], st_r.last[w], st_r.chan_en[w]),
        st_r.disc_cnt[w]);
      // A long input pulse keeps the digitiser line high as well
      st_nxt.tdc[w] = (st_nxt.disc_cnt[w] != '0) | (st_r.sync2[w] & st_r.chan_en[w]);

      // Retriggerable drift-time one-shot
      st_nxt.os_cnt[w] = os_step(st_r.sep_out[w], st_r.os_cnt[w]);
      // Output high while the count is nonzero
      st_nxt.trig[w] = st_nxt.os_cnt[w] != '0;
    end
  end

  // State register
  // The clock enable freezes every field, synchronisers included
  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= '0;
      st_r.chan_en <= whst_pkg::CHAN_EN_RESET;
      for (int p = 0; p < NP; p++)
        st_r.pstate[p] <= whst_pkg::WHST_ARMED;
    end
    else if (clk_en_i)
    begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign chan_en_o = st_r.chan_en;
  assign sep_hit_o = st_r.latch;
  assign tdc_pulse_o = st_r.tdc;
  assign trig_o = st_r.trig;

endmodule
`default_nettype wire

// ### bench/whst_props.sv
// Checker of separator, stretcher and one-shot timing
`timescale 1ns/1ps
`default_nettype none
module whst_props
(
  // Clock, reset, enable load
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic chan_en_we_i,
  input wire logic [whst_pkg::NUM_WIRES-1:0] chan_en_data_i,
  // Watched outputs
  input wire logic [whst_pkg::NUM_WIRES-1:0] chan_en_o,
  input wire logic [whst_pkg::NUM_WIRES-1:0] sep_hit_o,
  input wire logic [whst_pkg::NUM_WIRES-1:0] tdc_pulse_o,
  input wire logic [whst_pkg::NUM_WIRES-1:0] trig_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  // Three held cycles, then rearm
  sequence sep_hold;
    sep_hit_o[0] [*3] ##1 !sep_hit_o[0];
  endsequence
  pair_excl_a: assert property ((sep_hit_o & (sep_hit_o >> 1) & 24'h555555) == 24'h0) else $error("pair both won");
  rearm_time_a: assert property ($rose(sep_hit_o[0]) |-> sep_hold) else $error("hold not 60 ns");
  late_supp_a: assert property ($rose(trig_o[1]) |-> $past(sep_hit_o[1])) else $error("trig without win");
  tdc_width_a: assert property ($rose(tdc_pulse_o[0]) |=> tdc_pulse_o[0]) else $error("tdc pulse short");
  os_fire_a: assert property ($rose(sep_hit_o[0]) |=> trig_o[0] [*2]) else $error("one-shot not fired");
  os_width_a: assert property ($fell(trig_o[0]) |-> $past(sep_hit_o[0], 41) && !$past(sep_hit_o[0], 42))
    else $error("one-shot width wrong");
  en_load_a: assert property (chan_en_we_i |=> chan_en_o == $past(chan_en_data_i)) else $error("enable not loaded");
  en_block_a: assert property ($rose(sep_hit_o[0]) |-> $past(chan_en_o[0])) else $error("disabled wire won");
endmodule
`default_nettype wire

// ### bench/whst_card.sv
// Readout control card model: test pulser and hit map sampler
`timescale 1ns/1ps
`default_nettype none
module whst_card
(
  // Clock and one-shot levels
  input wire logic mclk_i,
  input wire logic [whst_pkg::NUM_WIRES-1:0] trig_i,
  // Pulser wires and sampled map
  output logic [whst_pkg::NUM_WIRES-1:0] pulse_o,
  output logic [whst_pkg::NUM_WIRES-1:0] hit_map_o
);
  initial pulse_o = 24'h0;
  // One cycle on mask a, then one on mask b, set on falling edges
  task automatic fire(input logic [whst_pkg::NUM_WIRES-1:0] a, b);
    @(negedge mclk_i) pulse_o = a;
    @(negedge mclk_i) pulse_o = b;
    @(negedge mclk_i) pulse_o = 24'h0;
  endtask
  // Strobe samples every one-shot each cycle; six-crossing span kept by width
  // Scintillator delay by the drift interval lies outside this model
  always @(posedge mclk_i) hit_map_o <= trig_i;
endmodule
`default_nettype wire

// ### bench/tb_wire_hit_separator_trigger.sv
// Testbench of the wire hit separator and trigger block
`timescale 1ns/1ps
`default_nettype none
module tb_wire_hit_separator_trigger;
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic chan_en_we_i = 1'b0;
  logic [whst_pkg::NUM_WIRES-1:0] chan_en_data_i = 24'hFFFFFF;
  logic [whst_pkg::NUM_WIRES-1:0] wires, chan_en_o, sep_hit_o, tdc_pulse_o, trig_o, map;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  always #10 mclk_i = ~mclk_i;
  whst_card u_card (.mclk_i(mclk_i), .trig_i(trig_o), .pulse_o(wires), .hit_map_o(map));
  whst_top dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .clk_en_i(1'b1), .wire_hit_i(wires),
    .chan_en_we_i(chan_en_we_i), .chan_en_data_i(chan_en_data_i), .chan_en_o(chan_en_o),
    .sep_hit_o(sep_hit_o), .tdc_pulse_o(tdc_pulse_o), .trig_o(trig_o));
  task automatic chk(input logic [whst_pkg::NUM_WIRES-1:0] seen, exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic gap(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  // Single hit: separator win, map, full one-shot width
  task automatic t_single();
    int n;
    u_card.fire(24'h1, 24'h0);
    for (n = 0; n < 8 && trig_o[0] !== 1'b1; n++) gap(1);
    chk(sep_hit_o & 24'h3, 24'h1);
    chk(tdc_pulse_o & 24'h3, 24'h1);
    gap(1);
    chk(map & 24'h1, 24'h1);
    for (n = 1; n < 60 && trig_o[0] === 1'b1; n++) gap(1);
    chk(24'(n), 24'(whst_pkg::DRIFT_CYC));
  endtask
  // Tie, later hit suppressed, rearm, then retrigger
  task automatic t_pairs();
    u_card.fire(24'hC, 24'h0);
    gap(6);
    chk(trig_o & 24'hC, 24'h4);
    u_card.fire(24'h10, 24'h20);
    gap(6);
    chk(trig_o & 24'h30, 24'h10);
    gap(4);
    u_card.fire(24'h20, 24'h0);
    gap(8);
    chk(trig_o & 24'h30, 24'h30);
    u_card.fire(24'h40, 24'h0);
    gap(20);
    u_card.fire(24'h40, 24'h0);
    gap(30);
    chk(trig_o & 24'h40, 24'h40);
  endtask
  // Disabled channel gives nothing
  task automatic t_enable();
    chan_en_we_i = 1'b1;
    chan_en_data_i = 24'hFFFEFF;
    gap(1);
    chan_en_we_i = 1'b0;
    chk(chan_en_o, 24'hFFFEFF);
    u_card.fire(24'h100, 24'h0);
    gap(8);
    chk((sep_hit_o | trig_o) & 24'h100, 24'h0);
  endtask
  // Run ceiling
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      n_mismatch++;
      end_sim();
    end
  end
  // Main sequence
  initial
  begin
    gap(12);
    reset_n_i = 1'b1;
    gap(3);
    chk(chan_en_o, whst_pkg::CHAN_EN_RESET);
    t_single();
    t_pairs();
    t_enable();
    end_sim();
  end
endmodule
bind whst_top whst_props u_props (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .chan_en_we_i(chan_en_we_i),
  .chan_en_data_i(chan_en_data_i), .chan_en_o(chan_en_o), .sep_hit_o(sep_hit_o),
  .tdc_pulse_o(tdc_pulse_o), .trig_o(trig_o));
`default_nettype wire
